// file: rtl/io_cell.sv
`timescale 1ns/1ps
module io_cell (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Async reset, low
  input wire logic registered, // Use the cell register
  input wire logic is_output, // Cell drives its pin
  input wire logic route_bit, // Data from the channel multiplexer
  input wire logic pin_bit, // Synchronised pin level
  input wire logic ce_bit, // Selected clock gate
  input wire logic [1:0] clk_sel, // 0 core, 1 slot clock 0, 2 slot clock 1
  input wire logic [1:0] io_clk, // Slot clocks
  input wire logic clr_bit, // Selected slot clear
  input wire logic chip_clear, // Chip-wide clear
  output logic io_val // Cell value
);

  logic d;
  logic d_ff;
  logic q_ff;
  logic [1:0] clk_prev_ff;
  logic tick;

  assign d = is_output ? route_bit : pin_bit;

  // Slot clocks are sampled fabric levels, so a rising edge becomes a tick
  always_comb begin
    case (clk_sel)
      2'h0: tick = 1'b1;
      2'h1: tick = io_clk[0] & ~clk_prev_ff[0];
      2'h2: tick = io_clk[1] & ~clk_prev_ff[1];
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      clk_prev_ff <= 2'h0;
    end else begin
      clk_prev_ff <= io_clk;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      d_ff <= 1'b0;
    end else begin
      d_ff <= d;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q_ff <= 1'b0;
    end else if (chip_clear) begin
      q_ff <= 1'b0; // R05 R13
    end else if (clr_bit) begin
      q_ff <= 1'b0;
    end else if (tick && ce_bit) begin
      q_ff <= d;
    end
  end

  assign io_val = registered ? q_ff : d_ff;

  sequence s_chip_clear;
    chip_clear;
  endsequence

  property p_clear_wins;
    @(posedge core_clk) disable iff (!resetn)
    s_chip_clear |=> (q_ff == 1'b0);
  endproperty

  clear_override_a: assert property (p_clear_wins) // R13
    else $error("io register not cleared by chip-wide clear");

  capture_data_a: assert property (@(posedge core_clk) disable iff (!resetn) // R05
    (!chip_clear && !clr_bit && tick && ce_bit) |=> (q_ff == $past(d)))
    else $error("io register missed an enabled capture");

endmodule // io_cell

// file: rtl/io_control_and_row_column_routing.sv
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module io_control_and_row_column_routing #(
  parameter int NUM_ROWS = io_route_pkg::DEF_ROWS,
  parameter int ROW_CH = io_route_pkg::DEF_ROW_CH,
  parameter int ROW_SEL = io_route_pkg::DEF_ROW_SEL,
  parameter int COL_CH = io_route_pkg::DEF_COL_CH,
  parameter int COL_SEL = io_route_pkg::DEF_COL_SEL,
  parameter int NUM_ROW_IO = 2 * io_route_pkg::ROW_END_IO,
  parameter int NUM_COL_IO = 2 * io_route_pkg::COL_END_IO,
  parameter int SLOT_ROW [io_route_pkg::SLOTS] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 3, 4, 5}
) (
  input wire logic core_clk, // Core clock
  input wire logic resetn, // Async reset, low
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [NUM_ROWS-1:0] row_lead_cell, // First logic cell of each row
  input wire logic [ROW_CH-1:0] row_ch, // Row channels from the fabric
  input wire logic [COL_CH-1:0] col_ch, // Column channels from the fabric
  output logic [ROW_CH-1:0] row_drive, // Row channels driven by input cells
  output logic [COL_CH-1:0] col_drive, // Column channels driven by input cells
  output logic [3:0] low_skew_net, // Low skew global nets
  input wire logic [NUM_ROW_IO+NUM_COL_IO-1:0] pin_in, // Pin levels
  output logic [NUM_ROW_IO+NUM_COL_IO-1:0] pin_out, // Pin output data
  output logic [NUM_ROW_IO+NUM_COL_IO-1:0] pin_oe, // Pin output enables
  input wire logic chipwide_tristate_control, // Float all outputs, high
  input wire logic chip_clear_n // Chip-wide I/O register clear, low
);

  localparam int NUM_IO = NUM_ROW_IO + NUM_COL_IO;

  // ----------------------------------------------------------------
  // Channel windows
  // ----------------------------------------------------------------
  // Each end of a row holds eight cells whose windows tile the row
  function automatic int row_base(input int idx);
    return (idx % io_route_pkg::ROW_END_IO) * ROW_SEL; // R08 R09
  endfunction

  // Column windows step by an even share of the spare channels
  function automatic int col_base(input int idx);
    return idx * ((COL_CH - COL_SEL) / (2 * io_route_pkg::COL_END_IO - 1)); // R11 R12
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [NUM_IO+1:0] sync_meta_ff;
  logic [NUM_IO+1:0] sync_ff;
  logic [NUM_IO-1:0] pin_sync;
  logic tri_sync;
  logic chip_clear;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      sync_meta_ff <= {~chip_clear_n, chipwide_tristate_control, pin_in};
      sync_ff <= sync_meta_ff;
    end
  end

  assign pin_sync = sync_ff[NUM_IO-1:0];
  assign tri_sync = sync_ff[NUM_IO];
  assign chip_clear = sync_ff[NUM_IO+1];

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [31:0] cfg_ff [NUM_IO];
  logic [31:0] ctrl_ff;
  logic [31:0] rdata_ff;
  logic run;
  logic tri_opt;
  logic [NUM_IO-1:0] io_val;
  logic [3:0] net_ff;
  logic [io_route_pkg::SLOTS-1:0] slot_val;

  assign run = ctrl_ff[io_route_pkg::CTRL_RUN];
  assign tri_opt = ctrl_ff[io_route_pkg::CTRL_TRI_OPT];

  // Selects only change while stopped, so no glitch reaches a pin mid-run
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_IO; i++) begin
        cfg_ff[i] <= io_route_pkg::CFG_RST;
      end
    end else if (reg_wr && !run) begin
      for (int i = 0; i < NUM_IO; i++) begin
        if (reg_addr == io_route_pkg::CFG_BASE + 8'(4 * i)) begin
          cfg_ff[i] <= reg_wdata; // R15
        end
      end
    end
  end

  // Roles are locked by run as well; clearing run is always allowed
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= io_route_pkg::CTRL_RST;
    end else if (reg_wr && reg_addr == io_route_pkg::CTRL_OFS) begin
      if (run) begin
        ctrl_ff[io_route_pkg::CTRL_RUN] <= reg_wdata[io_route_pkg::CTRL_RUN]; // R15
      end else begin
        ctrl_ff <= {18'h0, reg_wdata[13:0]};
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 32'h0;
    end else if (reg_rd) begin
      rdata_ff <= 32'h0;
      if (reg_addr == io_route_pkg::CTRL_OFS) begin
        rdata_ff <= ctrl_ff;
      end else if (reg_addr == io_route_pkg::PIN_STAT_OFS) begin
        rdata_ff <= 32'(pin_sync);
      end else if (reg_addr == io_route_pkg::NET_STAT_OFS) begin
        rdata_ff <= {16'h0, slot_val, net_ff};
      end else begin
        for (int i = 0; i < NUM_IO; i++) begin
          if (reg_addr == io_route_pkg::CFG_BASE + 8'(4 * i)) begin
            rdata_ff <= cfg_ff[i];
          end
        end
      end
    end
  end

  assign reg_rdata = rdata_ff;

  // ----------------------------------------------------------------
  // Peripheral control bus
  // ----------------------------------------------------------------
  io_route_pkg::slot_role_e role [io_route_pkg::SLOTS];
  logic [7:0] drive_gate;
  logic [5:0] clk_gate;
  logic [1:0] io_clock;
  logic [1:0] io_clear;

  always_comb begin
    for (int s = 0; s < io_route_pkg::SLOTS; s++) begin
      slot_val[s] = row_lead_cell[SLOT_ROW[s]]; // R01 R03
      role[s] = io_route_pkg::ROLE_CLK_GATE;
    end
    for (int k = 0; k < 6; k++) begin
      role[6 + k] = io_route_pkg::slot_role_e'(ctrl_ff[2 * k +: 2]);
    end
  end

  // Each shared slot serves one role at a time, which caps every category
  always_comb begin
    drive_gate[5:0] = slot_val[5:0]; // R01
    drive_gate[6] = (role[7] == io_route_pkg::ROLE_ALT) & slot_val[7]; // R14
    drive_gate[7] = (role[9] == io_route_pkg::ROLE_ALT) & slot_val[9]; // R14
    for (int k = 0; k < 6; k++) begin
      clk_gate[k] = (role[6 + k] == io_route_pkg::ROLE_CLK_GATE) & slot_val[6 + k]; // R14
    end
    io_clock[0] = (role[6] == io_route_pkg::ROLE_ALT) & slot_val[6]; // R14
    io_clock[1] = (role[11] == io_route_pkg::ROLE_ALT) & slot_val[11];
    io_clear[0] = (role[8] == io_route_pkg::ROLE_ALT) & slot_val[8];
    io_clear[1] = (role[10] == io_route_pkg::ROLE_ALT) & slot_val[10];
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      net_ff <= 4'h0;
    end else begin
      for (int g = 0; g < io_route_pkg::GLOBALS; g++) begin
        net_ff[g] <= (role[io_route_pkg::GLB_SLOT[g]] == io_route_pkg::ROLE_GLOBAL) &
                     slot_val[io_route_pkg::GLB_SLOT[g]]; // R02 R03
      end
    end
  end

  assign low_skew_net = net_ff;

  // ----------------------------------------------------------------
  // I/O cells
  // ----------------------------------------------------------------
  logic [NUM_IO-1:0] is_out;
  logic [NUM_IO-1:0] route_bit;

  for (genvar i = 0; i < NUM_IO; i++) begin : g_cell
    logic [5:0] row_pick;
    logic [5:0] col_pick;
    logic [2:0] oe_sel;
    logic [2:0] ce_sel;
    logic [7:0] ce_vec;
    logic [3:0] clr_vec;

    assign row_pick = cfg_ff[i][io_route_pkg::CFG_ROW_PICK_LSB +: 6];
    assign col_pick = cfg_ff[i][io_route_pkg::CFG_COL_PICK_LSB +: 6];
    assign oe_sel = cfg_ff[i][io_route_pkg::CFG_OE_LSB +: 3];
    assign ce_sel = cfg_ff[i][io_route_pkg::CFG_CE_LSB +: 3];
    assign is_out[i] = cfg_ff[i][io_route_pkg::CFG_IS_OUT];
    // Select 6 means no gate available, select 7 means always enabled
    assign ce_vec = {1'b1, 1'b0, clk_gate};
    assign clr_vec = {1'b0, io_clear, 1'b0};

    always_comb begin
      int idx;
      idx = 0;
      route_bit[i] = 1'b0;
      if (i < NUM_ROW_IO) begin
        idx = row_base(i) + int'(row_pick);
        if (int'(row_pick) < ROW_SEL && idx < ROW_CH) begin
          route_bit[i] = row_ch[idx]; // R07 R09
        end
      end else begin
        idx = col_base(i - NUM_ROW_IO) + int'(col_pick);
        if (int'(col_pick) < COL_SEL && idx < COL_CH) begin
          route_bit[i] = col_ch[idx]; // R11 R12
        end
      end
    end

    io_cell u_cell (
      .core_clk(core_clk),
      .resetn(resetn),
      .registered(cfg_ff[i][io_route_pkg::CFG_REGISTERED]),
      .is_output(is_out[i]),
      .route_bit(route_bit[i]),
      .pin_bit(pin_sync[i]),
      .ce_bit(ce_vec[ce_sel]),
      .clk_sel(cfg_ff[i][io_route_pkg::CFG_CLK_LSB +: 2]),
      .io_clk(io_clock),
      .clr_bit(clr_vec[cfg_ff[i][io_route_pkg::CFG_CLR_LSB +: 2]]),
      .chip_clear(chip_clear), // R05
      .io_val(io_val[i])
    );

    assign pin_out[i] = is_out[i] & io_val[i];
    assign pin_oe[i] = is_out[i] & drive_gate[oe_sel] & ~(tri_opt & tri_sync); // R04
  end

  // Two channels per input cell keep each channel to a single driver
  always_comb begin
    row_drive = '0;
    col_drive = '0;
    for (int i = 0; i < NUM_ROW_IO; i++) begin
      row_drive[2 * i +: 2] = {2{~is_out[i] & io_val[i]}}; // R06
    end
    for (int j = 0; j < NUM_COL_IO; j++) begin
      col_drive[2 * j +: 2] = {2{~is_out[NUM_ROW_IO + j] & io_val[NUM_ROW_IO + j]}}; // R10
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (!resetn);

  sequence s_running;
    run && $past(run);
  endsequence

  sequence s_global_role;
    role[6] == io_route_pkg::ROLE_GLOBAL;
  endsequence

  tristate_all_a: assert property ((tri_opt && tri_sync) |-> (pin_oe == '0)) // R04
    else $error("output enabled while chip-wide tristate is active");

  cfg_static_a: assert property (s_running |-> ($stable(cfg_ff[0]) && $stable(ctrl_ff))) // R15
    else $error("routing configuration changed while running");

  global_net_a: assert property (s_global_role |=> // R02
    (low_skew_net[0] == $past(row_lead_cell[SLOT_ROW[6]])))
    else $error("global net 0 does not follow its slot");

  global_off_a: assert property ((role[11] != io_route_pkg::ROLE_GLOBAL) |=> // R03
    (low_skew_net[3] == 1'b0))
    else $error("global net 3 driven without global role");

  gate_alt_a: assert property ((role[7] != io_route_pkg::ROLE_ALT) |-> !drive_gate[6]) // R14
    else $error("extra drive gate active without alternate role");

  row_input_a: assert property (!is_out[0] |-> (row_drive[1:0] == {2{io_val[0]}})) // R06
    else $error("input cell does not drive its two row channels");

  row_mux_a: assert property ((int'(g_cell[1].row_pick) < ROW_SEL) |-> // R07
    (route_bit[1] == row_ch[row_base(1) + int'(g_cell[1].row_pick)]))
    else $error("row multiplexer picked the wrong channel");

  col_mux_a: assert property ((int'(g_cell[NUM_ROW_IO].col_pick) < COL_SEL) |-> // R11
    (route_bit[NUM_ROW_IO] == col_ch[col_base(0) + int'(g_cell[NUM_ROW_IO].col_pick)]))
    else $error("column multiplexer picked the wrong channel");

  clear_path_a: assert property ((!chip_clear_n)[*3] |-> ##1 // R05
    (chip_clear && (g_cell[3].u_cell.q_ff == 1'b0)))
    else $error("chip-wide clear did not reach the io cells");

endmodule // io_control_and_row_column_routing

// file: rtl/io_route_pkg.sv
// Summary of operation
// [R01] Twelve control slots from fixed rows; six drive gates, six clock gates with alternates.
// [R02] Four slots can drive low skew nets zero through three.
// [R03] Logic cell drives a net via row line, control slot, then net.
// [R04] With the tristate option set, the high input floats every output pin.
// [R05] The chip-wide clear input clears every I/O cell register.
// [R06] An input I/O cell drives two row channels seen by the whole row.
// [R07] An output I/O cell takes its data from a row channel multiplexer.
// [R08] At most eight I/O cells sit on each end of a row.
// [R09] Rows carry 216 or 312 channels; each pin selects among 27 or 39.
// [R10] An input I/O cell drives at most two column channels.
// [R11] Output column cells use a column multiplexer; windows differ per cell.
// [R12] Columns carry 24, 32 or 48 channels; pins select among 16, 24 or 40.
// [R13] The chip-wide clear overrides every other I/O register control.
// [R14] At most eight drive gates, six clock gates, two clocks, two clears.
// [R15] All selects and slot roles are static while the block runs.
package io_route_pkg;

  // ----------------------------------------------------------------
  // Structure
  // ----------------------------------------------------------------
  localparam int SLOTS = 12;
  localparam int ROW_END_IO = 8;
  localparam int COL_END_IO = 2;
  localparam int GLOBALS = 4;
  localparam int DEF_ROWS = 6;
  localparam int DEF_ROW_CH = 216;
  localparam int DEF_ROW_SEL = 27;
  localparam int DEF_COL_CH = 24;
  localparam int DEF_COL_SEL = 16;
  localparam int GLB_SLOT [GLOBALS] = '{6, 7, 9, 11};

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_BASE = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h80;
  localparam logic [7:0] PIN_STAT_OFS = 8'h84;
  localparam logic [7:0] NET_STAT_OFS = 8'h88;
  localparam int CFG_ROW_PICK_LSB = 0;
  localparam int CFG_COL_PICK_LSB = 6;
  localparam int CFG_REGISTERED = 13;
  localparam int CFG_IS_OUT = 14;
  localparam int CFG_OE_LSB = 15;
  localparam int CFG_CE_LSB = 18;
  localparam int CFG_CLK_LSB = 21;
  localparam int CFG_CLR_LSB = 23;
  localparam int CTRL_ROLE_LSB = 0;
  localparam int CTRL_TRI_OPT = 12;
  localparam int CTRL_RUN = 13;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;

  typedef enum logic [1:0] {
    ROLE_CLK_GATE = 2'b00,
    ROLE_ALT = 2'b01,
    ROLE_GLOBAL = 2'b10,
    ROLE_OFF = 2'b11
  } slot_role_e;

endpackage

// file: verification/fabric_pin_model.sv
`timescale 1ns/1ps
module fabric_pin_model #(
  parameter int NIO = 20
) (
  input wire logic core_clk, // Core clock
  input wire logic [215:0] fab_row, // Row values the fabric wants
  input wire logic [23:0] fab_col, // Column values the fabric wants
  input wire logic [5:0] fab_lead, // Lead cell values the fabric wants
  input wire logic [NIO-1:0] ext_en, // Board drives the pin
  input wire logic [NIO-1:0] ext_val, // Board pin level
  input wire logic [NIO-1:0] pin_out, // Pin data from the block
  input wire logic [NIO-1:0] pin_oe, // Pin enables from the block
  output logic [215:0] row_ch = '0, // Row channels to the block
  output logic [23:0] col_ch = '0, // Column channels to the block
  output logic [5:0] row_lead_cell = '0, // Lead cells to the block
  output logic [NIO-1:0] pin_in // Resolved pin levels
);
  // ----------------------------------------------------------------
  // Logic cells
  // ----------------------------------------------------------------
  // Fabric values leave cell flops, so they change only on the clock
  always @(posedge core_clk) begin
    row_ch <= fab_row;
    col_ch <= fab_col;
    row_lead_cell <= fab_lead;
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  // Board pull-down: a pin nobody drives reads low, never the last value
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val);
endmodule // fabric_pin_model

// file: verification/io_control_and_row_column_routing_tb.sv
`timescale 1ns/1ps
module io_control_and_row_column_routing_tb;
  localparam int NIO = 20;
  localparam logic [31:0] RUN = 32'h1 << io_route_pkg::CTRL_RUN;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [5:0] row_lead_cell;
  logic [215:0] row_ch;
  logic [215:0] row_drive;
  logic [23:0] col_ch;
  logic [23:0] col_drive;
  logic [3:0] low_skew_net;
  logic [NIO-1:0] pin_in;
  logic [NIO-1:0] pin_out;
  logic [NIO-1:0] pin_oe;
  logic tri_ctl = 1'b0;
  logic clear_n = 1'b1;
  logic [215:0] fab_row = '0;
  logic [23:0] fab_col = '0;
  logic [5:0] fab_lead = '0;
  logic [NIO-1:0] ext_en = '0;
  logic [NIO-1:0] ext_val = '0;
  logic [31:0] rv;
  int n_fail = 0;
  int checks = 0;

  initial begin
    forever #5 core_clk = ~core_clk;
  end

  io_control_and_row_column_routing dut (
    .core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .row_lead_cell(row_lead_cell),
    .row_ch(row_ch), .col_ch(col_ch), .row_drive(row_drive), .col_drive(col_drive),
    .low_skew_net(low_skew_net), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .chipwide_tristate_control(tri_ctl), .chip_clear_n(clear_n)
  );

  fabric_pin_model #(.NIO(NIO)) far_side (
    .core_clk(core_clk), .fab_row(fab_row), .fab_col(fab_col), .fab_lead(fab_lead),
    .ext_en(ext_en), .ext_val(ext_val), .pin_out(pin_out), .pin_oe(pin_oe),
    .row_ch(row_ch), .col_ch(col_ch), .row_lead_cell(row_lead_cell), .pin_in(pin_in)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data appear in the cycle after the strobe and stand until the next read strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  function automatic logic [31:0] cfgw(input int rp, cp, rg, o, oe, ce);
    return 32'(rp) << io_route_pkg::CFG_ROW_PICK_LSB | 32'(cp) << io_route_pkg::CFG_COL_PICK_LSB
      | 32'(rg) << io_route_pkg::CFG_REGISTERED | 32'(o) << io_route_pkg::CFG_IS_OUT
      | 32'(oe) << io_route_pkg::CFG_OE_LSB | 32'(ce) << io_route_pkg::CFG_CE_LSB;
  endfunction

  // Selects may only change while stopped, so stop, load, then run again
  task automatic setup(input int i, input logic [31:0] w, input logic [31:0] ctl);
    wr(io_route_pkg::CTRL_OFS, 32'h0000_0000);
    wr(io_route_pkg::CFG_BASE + 8'(4 * i), w);
    wr(io_route_pkg::CTRL_OFS, ctl | RUN);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("pin_oe", '0, 32'(pin_oe));
    rd(io_route_pkg::CTRL_OFS, rv);
    chk("ctrl", io_route_pkg::CTRL_RST, rv);
    rd(io_route_pkg::CFG_BASE + 8'h4c, rv);
    chk("cfg19", io_route_pkg::CFG_RST, rv);
    wr(8'hfc, 32'hffff_ffff);
    rd(8'hfc, rv);
    chk("unmapped", 32'h0000_0000, rv);
  endtask

  task automatic t_row_out();
    int pick;
    for (int g = 0; g < 6; g++) begin
      pick = g * 5 + ((g == 5) ? 1 : 0);
      setup(1, cfgw(pick, 0, 0, 1, g, 0), 32'h0000_0000);
      fab_lead <= 6'(1 << g);
      fab_row <= 216'(1) << (io_route_pkg::DEF_ROW_SEL + pick);
      cyc(4);
      chk("row pin_out", 32'h1, 32'(pin_out[1]));
      chk("gate pin_oe", 32'h1, 32'(pin_oe[1]));
      fab_lead <= 6'h00;
      fab_row <= '0;
      cyc(4);
      chk("row pin_out off", 32'h0, 32'(pin_out[1]));
      chk("gate pin_oe off", 32'h0, 32'(pin_oe[1]));
    end
    setup(1, cfgw(io_route_pkg::DEF_ROW_SEL, 0, 0, 1, 0, 0), 32'h0000_0000);
    fab_row <= '1;
    cyc(4);
    chk("pick beyond window", 32'h0, 32'(pin_out[1]));
    fab_row <= '0;
  endtask

  task automatic t_col_out();
    for (int j = 0; j < 4; j++) begin
      setup(16 + j, cfgw(0, 15, 0, 1, 0, 0), 32'h0000_0000);
    end
    fab_lead <= 6'h01;
    for (int j = 0; j < 4; j++) begin
      fab_col <= 24'(1) << (2 * j + 15);
      cyc(4);
      chk("col pins", 32'(1 << j), 32'(pin_out[19:16]));
    end
    fab_col <= '0;
  endtask

  task automatic t_input();
    setup(2, 32'h0000_0000, 32'h0000_0000);
    setup(18, 32'h0000_0000, 32'h0000_0000);
    ext_en <= 20'h4_0004;
    ext_val <= 20'h4_0004;
    cyc(5);
    chk("row_drive", 32'h30, 32'(row_drive[5:0]));
    chk("col_drive", 32'h30, 32'(col_drive[5:0]));
    rd(io_route_pkg::PIN_STAT_OFS, rv);
    chk("pin_stat", 32'h0004_0004, rv);
    ext_val <= 20'h0_0000;
    cyc(5);
    chk("row_drive low", 32'h0, 32'(row_drive[5:0]));
    chk("col_drive low", 32'h0, 32'(col_drive[5:0]));
    ext_en <= 20'h0_0000;
  endtask

  task automatic t_tristate();
    setup(1, cfgw(3, 0, 0, 1, 0, 0), 32'h0000_0000);
    fab_lead <= 6'h01;
    @(posedge core_clk);
    tri_ctl <= 1'b1;
    cyc(4);
    chk("no option", 32'h1, 32'(pin_oe[1]));
    wr(io_route_pkg::CTRL_OFS, 32'h0000_0000);
    wr(io_route_pkg::CTRL_OFS, (32'h1 << io_route_pkg::CTRL_TRI_OPT) | RUN);
    cyc(4);
    chk("all floated", 32'h0, 32'(pin_oe));
    @(posedge core_clk);
    tri_ctl <= 1'b0;
    cyc(4);
    chk("driven again", 32'h1, 32'(pin_oe[1]));
  endtask

  task automatic t_global();
    int s;
    for (int g = 0; g < 4; g++) begin
      s = io_route_pkg::GLB_SLOT[g];
      wr(io_route_pkg::CTRL_OFS, 32'h0000_0000);
      wr(io_route_pkg::CTRL_OFS, (32'h2 << (2 * (s - 6))) | RUN);
      fab_lead <= 6'(1 << (s % 6));
      cyc(4);
      chk("net on", 32'(1 << g), 32'(low_skew_net));
      rd(io_route_pkg::NET_STAT_OFS, rv);
      chk("net_stat", (32'h041 << (s % 6)) << 4 | 32'(1 << g), rv);
      fab_lead <= 6'h00;
      cyc(4);
      chk("net off", 32'h0, 32'(low_skew_net));
    end
  endtask

  task automatic t_clear();
    setup(3, cfgw(0, 0, 1, 1, 0, 7), 32'h0000_0000);
    fab_lead <= 6'h01;
    fab_row <= 216'(1) << (3 * io_route_pkg::DEF_ROW_SEL);
    cyc(4);
    chk("held one", 32'h1, 32'(pin_out[3]));
    @(posedge core_clk);
    clear_n <= 1'b0;
    cyc(4);
    chk("cleared", 32'h0, 32'(pin_out[3]));
    @(posedge core_clk);
    clear_n <= 1'b1;
    cyc(4);
    chk("released", 32'h1, 32'(pin_out[3]));
    wr(io_route_pkg::CFG_BASE + 8'h0c, 32'h0000_0000);
    rd(io_route_pkg::CFG_BASE + 8'h0c, rv);
    chk("cfg locked", cfgw(0, 0, 1, 1, 0, 7), rv);
    chk("still one", 32'h1, 32'(pin_out[3]));
    fab_row <= '0;
  endtask

  // Slots 6, 7 and 8 in their alternate roles: slot clock, extra gate, slot clear
  task automatic t_alt();
    setup(3, cfgw(0, 0, 1, 1, 6, 7) | 32'h1 << io_route_pkg::CFG_CLK_LSB
      | 32'h1 << io_route_pkg::CFG_CLR_LSB, 32'h0000_0015);
    fab_row <= 216'(1) << (3 * io_route_pkg::DEF_ROW_SEL);
    fab_lead <= 6'h06;
    cyc(4);
    chk("slot clear", 32'h0, 32'(pin_out[3]));
    chk("extra gate", 32'h1, 32'(pin_oe[3]));
    @(posedge core_clk);
    fab_lead <= 6'h03;
    cyc(4);
    chk("slot clock", 32'h1, 32'(pin_out[3]));
    @(posedge core_clk);
    fab_row <= '0;
    cyc(4);
    chk("no clock edge", 32'h1, 32'(pin_out[3]));
    @(posedge core_clk);
    fab_lead <= 6'h00;
    cyc(4);
    chk("gate off", 32'h0, 32'(pin_oe[3]));
    chk("held", 32'h1, 32'(pin_out[3]));
  endtask

  task automatic results();
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    cyc(1);
    t_reset();
    t_row_out();
    t_col_out();
    t_input();
    t_tristate();
    t_global();
    t_clear();
    t_alt();
    results();
  end
endmodule // io_control_and_row_column_routing_tb
